// File: verilog/epio_port.sv
// Purpose: eight-bit I/O port with pin multiplexing
// Assumes: pins are outside the clock domain
// Notes: registers reached over AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
`include "epio_cfg.svh"

// Operation
// R1: Output bits read back the latch
// R2: Input bits read the pin level
// R3: Direction one drives latch, zero inputs
// R4: Alternate function overrides direction and latch
// R5: Direction register reads all ones
// R6: Reset clears registers, mode loads c0
// R7: Mode bits seven, six read one
// R8: Software writes zero to bits five, four
// R9: Mode bit three routes interrupt zero
// R10: Mode bit two selects serial buffer
// R11: Mode bit one selects count input
// R12: Reduced variant keeps bits two, one clear; code still stores and reads them, gating only their functions
// R13: Mode bit zero selects interrupt four
// R14: Trigger enable adds converter trigger role
// R15: Software disables interrupt four for trigger
// R16: Open-drain select per output pin
// R17: Hi-Z in reset, standby; hold sleeping
// R18: Open-drain one releases, zero pulls low
module epio_port #(
	parameter bit FULL_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// AXI4-Lite write
	input wire logic [`EPIO_AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read
	input wire logic [`EPIO_AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Port pins
	input wire logic [7:0] port_pin_i,
	output logic [7:0] port_pin_o,
	output logic [7:0] port_pin_oe_o,
	// Port 4 bit 3 pin
	input wire logic p4_3_pin_i,
	// Serial output pin
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	// Serial unit side
	input wire logic serial_data_i,
	input wire logic serial_drive_i,
	// System side
	input wire epio_pkg::epio_pwr_t power_mode_i,
	input wire logic adc_trigger_enable_i,
	// Alternate function inputs
	output logic p4_3_input_o,
	output logic ext_int0_o,
	output logic up_down_count_input_o,
	output logic ext_int4_o,
	output logic adc_external_trigger_o
);

	// ***************************************
	// Declarations
	// ***************************************

	epio_pkg::epio_wr_t wr;
	epio_pkg::epio_rd_t rd;
	logic [7:0] data_latch_ff;
	logic [7:0] dir_ff;
	logic [7:0] odsel_ff;
	logic [7:0] mode_ff;
	logic [8:0] sync_all;
	logic [7:0] pin_sync;
	logic p4_sync;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] rd_data;
	logic ext_int0_select;
	logic serial_out_pmos_off;
	logic ud_sel;
	logic ext_int4_select;
	logic [7:0] alt_mask;
	logic [7:0] nxt_pin_oe;
	logic [7:0] nxt_pin_o;
	logic nxt_so_oe;
	logic pins_live;
	logic pins_hold;
	logic [7:0] pin_o_ff;
	logic [7:0] pin_oe_ff;
	logic so_o_ff;
	logic so_oe_ff;

	// ***************************************
	// Helpers
	// ***************************************

	function automatic logic [15:0] idx_of(input logic [`EPIO_AW-1:0] a);
		idx_of = a[`EPIO_AW-1:2];
	endfunction

	function automatic logic mapped(input logic [15:0] idx);
		mapped = (idx == `EPIO_IDX_MODE) || (idx == `EPIO_IDX_ODSEL) ||
			(idx == `EPIO_IDX_DATA) || (idx == `EPIO_IDX_DIR);
	endfunction

	// ***************************************
	// Bus front end and pin synchroniser
	// ***************************************

	epio_axil u_axil (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.wr_o(wr),
		.wr_hit_i(wr_hit),
		.rd_o(rd),
		.rd_hit_i(rd_hit),
		.rd_data_i(rd_data)
	);

	epio_sync2 #(.W(9)) u_sync (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.async_i({p4_3_pin_i, port_pin_i}),
		.sync_o(sync_all)
	);

	assign pin_sync = sync_all[7:0];
	assign p4_sync = sync_all[8];

	// ***************************************
	// Registers
	// ***************************************

	assign wr_hit = mapped(idx_of(wr.addr));
	assign rd_hit = mapped(idx_of(rd.addr));

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			data_latch_ff <= `EPIO_RST_ZERO; // R6
		end else if (wr.valid && wr.strb0 && idx_of(wr.addr) == `EPIO_IDX_DATA) begin
			data_latch_ff <= wr.data;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			dir_ff <= `EPIO_RST_ZERO; // R6
		end else if (wr.valid && wr.strb0 && idx_of(wr.addr) == `EPIO_IDX_DIR) begin
			dir_ff <= wr.data;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			odsel_ff <= `EPIO_RST_ZERO; // R6
		end else if (wr.valid && wr.strb0 && idx_of(wr.addr) == `EPIO_IDX_ODSEL) begin
			odsel_ff <= wr.data;
		end
	end

	// Top two bits forced so they never change
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			mode_ff <= `EPIO_RST_MODE; // R6
		end else if (wr.valid && wr.strb0 && idx_of(wr.addr) == `EPIO_IDX_MODE) begin
			mode_ff <= wr.data | `EPIO_MODE_ONES; // R7
		end
	end

	// Read mux; unmapped reads return zero
	always_comb begin
		rd_data = 8'h00;
		case (idx_of(rd.addr))
			`EPIO_IDX_DATA: rd_data = (dir_ff & data_latch_ff) | (~dir_ff & pin_sync); // R1 R2
			`EPIO_IDX_DIR: rd_data = `EPIO_DIR_READ; // R5
			`EPIO_IDX_MODE: rd_data = mode_ff | `EPIO_MODE_ONES; // R7
			`EPIO_IDX_ODSEL: rd_data = odsel_ff;
			default: rd_data = 8'h00;
		endcase
	end

	// ***************************************
	// Pin function selection
	// ***************************************

	assign ext_int0_select = mode_ff[`EPIO_MB_INT0];
	// Reduced part has no count input or buffer option
	assign serial_out_pmos_off = FULL_VARIANT && mode_ff[`EPIO_MB_SOPOF]; // R12
	assign ud_sel = FULL_VARIANT && mode_ff[`EPIO_MB_UD]; // R12
	assign ext_int4_select = mode_ff[`EPIO_MB_INT4];

	always_comb begin
		alt_mask = 8'hff;
		alt_mask[`EPIO_PIN_UD] = !ud_sel; // R11
		alt_mask[`EPIO_PIN_INT4] = !ext_int4_select; // R13
	end

	// Open drain never drives high, only releases
	assign nxt_pin_oe = dir_ff & alt_mask & ~(odsel_ff & data_latch_ff); // R3 R4 R16 R18
	assign nxt_pin_o = data_latch_ff & ~odsel_ff; // R18
	assign nxt_so_oe = serial_drive_i && !(serial_out_pmos_off && serial_data_i); // R10

	assign pins_live = power_mode_i == epio_pkg::EPIO_PWR_ACTIVE ||
		power_mode_i == epio_pkg::EPIO_PWR_SUBACTIVE;
	assign pins_hold = power_mode_i == epio_pkg::EPIO_PWR_SLEEP ||
		power_mode_i == epio_pkg::EPIO_PWR_SUBSLEEP ||
		power_mode_i == epio_pkg::EPIO_PWR_WATCH;

	// ***************************************
	// Pin drivers
	// ***************************************

	// Unknown mode codes float the pins as the safe case
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			pin_o_ff <= `EPIO_RST_ZERO;
			pin_oe_ff <= `EPIO_RST_ZERO; // R17
		end else if (pins_live) begin
			pin_o_ff <= nxt_pin_o; // R3
			pin_oe_ff <= nxt_pin_oe; // R3
		end else if (!pins_hold) begin
			pin_oe_ff <= `EPIO_RST_ZERO; // R17
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			so_o_ff <= 1'b0;
			so_oe_ff <= 1'b0; // R17
		end else if (pins_live) begin
			so_o_ff <= serial_data_i;
			so_oe_ff <= nxt_so_oe; // R10
		end else if (!pins_hold) begin
			so_oe_ff <= 1'b0; // R17
		end
	end

	assign port_pin_o = pin_o_ff;
	assign port_pin_oe_o = pin_oe_ff;
	assign serial_out_pin_o = so_o_ff;
	assign serial_out_pin_oe_o = so_oe_ff;

	// ***************************************
	// Alternate function inputs
	// ***************************************

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			p4_3_input_o <= 1'b0;
			ext_int0_o <= 1'b0;
		end else begin
			p4_3_input_o <= !ext_int0_select && p4_sync; // R9
			ext_int0_o <= ext_int0_select && p4_sync; // R9
		end
	end

	// Interrupt masking is software's job when triggering
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			up_down_count_input_o <= 1'b0;
			ext_int4_o <= 1'b0;
			adc_external_trigger_o <= 1'b0;
		end else begin
			up_down_count_input_o <= ud_sel && pin_sync[`EPIO_PIN_UD]; // R11
			ext_int4_o <= ext_int4_select && pin_sync[`EPIO_PIN_INT4]; // R13
			adc_external_trigger_o <= ext_int4_select && adc_trigger_enable_i &&
				pin_sync[`EPIO_PIN_INT4]; // R14
		end
	end

	// ***************************************
	// Checks
	// ***************************************

	a_gpio_read_mux: assert property ( // R1
		@(posedge core_clk_i) disable iff (!resetn_i)
		rd.valid && idx_of(rd.addr) == `EPIO_IDX_DATA |=>
		s_axi_rdata_o[7:0] == $past((dir_ff & data_latch_ff) | (~dir_ff & pin_sync)))
		else $error("port read mixes latch and pins wrongly");

	a_dir_reads_ones: assert property ( // R5
		@(posedge core_clk_i) disable iff (!resetn_i)
		rd.valid && idx_of(rd.addr) == `EPIO_IDX_DIR |=>
		s_axi_rdata_o == {24'h000000, `EPIO_DIR_READ} && s_axi_rvalid_o)
		else $error("direction read not all ones");

	a_reset_values: assert property ( // R6
		@(posedge core_clk_i)
		!resetn_i |=> data_latch_ff == `EPIO_RST_ZERO && dir_ff == `EPIO_RST_ZERO &&
		odsel_ff == `EPIO_RST_ZERO && mode_ff == `EPIO_RST_MODE && port_pin_oe_o == '0)
		else $error("reset values wrong");

	a_mode_top_ones: assert property ( // R7
		@(posedge core_clk_i) disable iff (!resetn_i)
		(mode_ff & `EPIO_MODE_ONES) == `EPIO_MODE_ONES)
		else $error("mode top bits not one");

	a_gpio_drive: assert property ( // R3
		@(posedge core_clk_i) disable iff (!resetn_i)
		pins_live |=> port_pin_oe_o[7:2] ==
		$past(dir_ff[7:2] & ~(odsel_ff[7:2] & data_latch_ff[7:2])) &&
		port_pin_o[7:2] == $past(data_latch_ff[7:2] & ~odsel_ff[7:2]))
		else $error("gpio drive does not follow direction");

	a_ud_override: assert property ( // R11
		@(posedge core_clk_i) disable iff (!resetn_i)
		pins_live && ud_sel |=> !port_pin_oe_o[`EPIO_PIN_UD])
		else $error("count pin driven as output");

	a_int4_trigger: assert property ( // R14
		@(posedge core_clk_i) disable iff (!resetn_i)
		ext_int4_select && !adc_trigger_enable_i |=> !adc_external_trigger_o)
		else $error("trigger raised while disabled");

	a_int4_route: assert property ( // R13
		@(posedge core_clk_i) disable iff (!resetn_i)
		ext_int4_select ##1 ext_int4_select |->
		ext_int4_o == $past(pin_sync[`EPIO_PIN_INT4]) && !port_pin_oe_o[`EPIO_PIN_INT4])
		else $error("interrupt four pin misrouted");

	a_od_release: assert property ( // R18
		@(posedge core_clk_i) disable iff (!resetn_i)
		pins_live |=> (port_pin_oe_o & port_pin_o & $past(odsel_ff)) == 8'h00)
		else $error("open drain drives high");

	a_sleep_hold: assert property ( // R17
		@(posedge core_clk_i) disable iff (!resetn_i)
		pins_hold |=> $stable(port_pin_oe_o) && $stable(port_pin_o))
		else $error("pins changed in sleep");

	a_standby_hiz: assert property ( // R17
		@(posedge core_clk_i) disable iff (!resetn_i)
		power_mode_i == epio_pkg::EPIO_PWR_STANDBY |=>
		port_pin_oe_o == 8'h00 && !serial_out_pin_oe_o)
		else $error("pins driven in standby");

	a_int0_route: assert property ( // R9
		@(posedge core_clk_i) disable iff (!resetn_i)
		ext_int0_select |=> ext_int0_o == $past(p4_sync) && !p4_3_input_o)
		else $error("interrupt zero misrouted");

	a_so_pmos_off: assert property ( // R10
		@(posedge core_clk_i) disable iff (!resetn_i)
		pins_live && serial_out_pmos_off && serial_data_i |=> !serial_out_pin_oe_o)
		else $error("serial pin drives high with pmos off");

endmodule // epio_port
`default_nettype wire

// File: pkg/epio_cfg.svh
// Purpose: constants of the eight-bit port
// Assumes: included by package and design files
// Notes: register offsets are word indexes
`ifndef EPIO_CFG_SVH
`define EPIO_CFG_SVH
`define EPIO_AW 18
`define EPIO_IDX_MODE 16'hffc9
`define EPIO_IDX_ODSEL 16'hffcb
`define EPIO_IDX_DATA 16'hffd5
`define EPIO_IDX_DIR 16'hffe5
`define EPIO_RST_MODE 8'hc0
`define EPIO_RST_ZERO 8'h00
`define EPIO_MODE_ONES 8'hc0
`define EPIO_DIR_READ 8'hff
`define EPIO_MB_INT0 3
`define EPIO_MB_SOPOF 2
`define EPIO_MB_UD 1
`define EPIO_MB_INT4 0
`define EPIO_PIN_UD 1
`define EPIO_PIN_INT4 0
`define EPIO_RESP_OKAY 2'h0
`define EPIO_RESP_DECERR 2'h3
`endif

// File: pkg/epio_pkg.sv
// Purpose: types of the eight-bit port
// Assumes: epio_cfg.svh on the include path
// Notes: none
`include "epio_cfg.svh"
package epio_pkg;
	typedef struct packed {
		logic valid;
		logic [`EPIO_AW-1:0] addr;
		logic [7:0] data;
		logic strb0;
	} epio_wr_t;
	typedef struct packed {
		logic valid;
		logic [`EPIO_AW-1:0] addr;
	} epio_rd_t;
	typedef enum logic [5:0] {
		EPIO_PWR_ACTIVE = 6'h01,
		EPIO_PWR_SUBACTIVE = 6'h02,
		EPIO_PWR_SLEEP = 6'h04,
		EPIO_PWR_SUBSLEEP = 6'h08,
		EPIO_PWR_WATCH = 6'h10,
		EPIO_PWR_STANDBY = 6'h20
	} epio_pwr_t;
endpackage

// File: verilog/epio_sync2.sv
// Purpose: two-flop synchroniser
// Assumes: one clock
// Notes: first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module epio_sync2 #(
	parameter int W = 9
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule // epio_sync2
`default_nettype wire

// File: verilog/epio_axil.sv
// Purpose: AXI4-Lite slave front end
// Assumes: one write and one read at a time
// Notes: write answers one edge after the request is complete, read at the edge that takes the address
`timescale 1ns/1ns
`default_nettype none
`include "epio_cfg.svh"
module epio_axil (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Write channels
	input wire logic [`EPIO_AW-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// Read channels
	input wire logic [`EPIO_AW-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Register side
	output epio_pkg::epio_wr_t wr_o,
	input wire logic wr_hit_i,
	output epio_pkg::epio_rd_t rd_o,
	input wire logic rd_hit_i,
	input wire logic [7:0] rd_data_i
);
	logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
	logic [`EPIO_AW-1:0] aw_addr_ff;
	logic [7:0] w_data_ff;
	logic w_strb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic do_write;

	assign s_axi_awready_o = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready_o = !w_held_ff && !bvalid_ff;
	assign s_axi_arready_o = !rvalid_ff;
	assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_o = '{valid: do_write, addr: aw_addr_ff, data: w_data_ff, strb0: w_strb_ff};
	assign rd_o = '{valid: s_axi_arvalid_i && !rvalid_ff, addr: s_axi_araddr_i};

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			aw_held_ff <= 1'b0;
			aw_addr_ff <= '0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_held_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			w_held_ff <= 1'b0;
			w_data_ff <= '0;
			w_strb_ff <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_held_ff <= 1'b1;
			w_data_ff <= s_axi_wdata_i[7:0];
			w_strb_ff <= s_axi_wstrb_i[0];
		end else if (do_write) begin
			w_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `EPIO_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit_i ? `EPIO_RESP_OKAY : `EPIO_RESP_DECERR;
		end else if (s_axi_bready_i) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= `EPIO_RESP_OKAY;
			rdata_ff <= '0;
		end else if (rd_o.valid) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rd_hit_i ? `EPIO_RESP_OKAY : `EPIO_RESP_DECERR;
			rdata_ff <= {24'h000000, rd_data_i};
		end else if (s_axi_rready_i) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid_o = bvalid_ff;
	assign s_axi_bresp_o = bresp_ff;
	assign s_axi_rvalid_o = rvalid_ff;
	assign s_axi_rresp_o = rresp_ff;
	assign s_axi_rdata_o = rdata_ff;
endmodule // epio_axil
`default_nettype wire

// File: verification/epio_board.sv
// Purpose: board model on the far side of the port pins
// Assumes: pins resolved at the board, no pull resistors
// Notes: board drives a pin only while the port leaves it
`timescale 1ns/1ns
`default_nettype none
module epio_board (
	// From the port
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] pin_oe_i,
	// Board side levels
	input wire logic [7:0] drive_i,
	// To the port
	output logic [7:0] pin_i_o
);
	// Port wins where it drives; board level elsewhere
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			pin_i_o[n] = pin_oe_i[n] ? pin_o_i[n] : drive_i[n];
		end
	end
endmodule // epio_board
`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench of the eight-bit port
// Assumes: package and config header compiled first
// Notes: read results are checked from a queue of notes
`timescale 1ns/1ns
`default_nettype none
`include "epio_cfg.svh"
module testbench;
	localparam logic [17:0] a_mode = {`EPIO_IDX_MODE, 2'b00};
	localparam logic [17:0] a_ods = {`EPIO_IDX_ODSEL, 2'b00};
	localparam logic [17:0] a_data = {`EPIO_IDX_DATA, 2'b00};
	localparam logic [17:0] a_dir = {`EPIO_IDX_DIR, 2'b00};
	localparam logic [17:0] a_bad = 18'h3ff00;
	localparam logic [1:0] ok = `EPIO_RESP_OKAY;
	localparam logic [1:0] dec = `EPIO_RESP_DECERR;
	logic clk, rstn = 1'b0;
	logic [17:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'h1;
	logic [1:0] bresp, rresp;
	logic [7:0] ext = 8'h5a, pin_i, pin_o, pin_oe;
	logic p43 = 1'b0, sdata = 1'b0, sdrv = 1'b0, trg = 1'b0;
	logic ser_o, ser_oe, p43_in, int0, ud, int4, adtr;
	epio_pkg::epio_pwr_t pwr = epio_pkg::EPIO_PWR_ACTIVE;
	logic [33:0] exp_q[$];
	int bad_count = 0, n_compared = 0, cyc = 0;

	epio_port #(.FULL_VARIANT(1'b1)) i_dut (.core_clk_i(clk), .resetn_i(rstn),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .port_pin_i(pin_i),
		.port_pin_o(pin_o), .port_pin_oe_o(pin_oe), .p4_3_pin_i(p43),
		.serial_out_pin_o(ser_o), .serial_out_pin_oe_o(ser_oe), .serial_data_i(sdata),
		.serial_drive_i(sdrv), .power_mode_i(pwr), .adc_trigger_enable_i(trg),
		.p4_3_input_o(p43_in), .ext_int0_o(int0), .up_down_count_input_o(ud),
		.ext_int4_o(int4), .adc_external_trigger_o(adtr));
	epio_board i_board (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .drive_i(ext), .pin_i_o(pin_i));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (awvalid && awready)
				ad = 1'b1;
			if (wvalid && wready)
				wd = 1'b1;
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
		end
		@(posedge clk);
		while (!bvalid)
			@(posedge clk);
		chk("write_resp", {32'h0, er}, {32'h0, bresp});
	endtask

	task automatic rd(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
		exp_q.push_back({er, 24'h0, d});
		araddr <= a;
		arvalid <= 1'b1;
		@(posedge clk);
		while (!arready)
			@(posedge clk);
		arvalid <= 1'b0;
		@(posedge clk);
		while (!rvalid)
			@(posedge clk);
	endtask

	// Oldest note answers each read; a read with no note fails
	always @(posedge clk) begin
		if (rvalid && rready)
			chk("read_result", exp_q.size() > 0 ? exp_q.pop_front() : '1, {rresp, rdata});
	end

	task automatic wrap_up();
		if (bad_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			wrap_up();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		int i;
		logic [7:0] dv, lv, od;
		epio_pkg::epio_pwr_t hm [3];
		hm = '{epio_pkg::EPIO_PWR_SLEEP, epio_pkg::EPIO_PWR_SUBSLEEP, epio_pkg::EPIO_PWR_WATCH};
		i = $urandom(32'hf03c);
		repeat (6) @(posedge clk);
		chk("pin_oe", 34'h0, {26'h0, pin_oe});
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(a_mode, 8'hc0, ok);
		rd(a_ods, 8'h00, ok);
		rd(a_dir, 8'hff, ok);
		rd(a_data, 8'h5a, ok);
		rd(a_bad, 8'h00, dec);
		wr(a_bad, 8'h55, dec);
		wr(a_mode, 8'h0f, ok);
		rd(a_mode, 8'hcf, ok);
		wr(a_mode, 8'h00, ok);
		for (i = 0; i < 6; i++) begin
			dv = 8'($urandom);
			lv = 8'($urandom);
			od = (i > 2) ? 8'($urandom) : 8'h00;
			ext <= 8'($urandom);
			wr(a_ods, od, ok);
			wr(a_dir, dv, ok);
			wr(a_data, lv, ok);
			repeat (2) @(posedge clk);
			chk("pin_oe", {26'h0, dv & ~(od & lv)}, {26'h0, pin_oe});
			chk("pin_out", {26'h0, dv & lv & ~od}, {26'h0, pin_o & pin_oe});
			rd(a_data, (dv & lv) | (~dv & ext), ok);
		end
		wr(a_ods, 8'h00, ok);
		wr(a_dir, 8'hff, ok);
		wr(a_data, 8'hff, ok);
		wr(a_mode, 8'h03, ok);
		for (i = 0; i < 4; i++) begin
			ext <= {6'h2a, i[1:0]};
			// Interrupt four enable assumed cleared by software here
			trg <= i[1];
			repeat (5) @(posedge clk);
			chk("pin_oe", 34'hfc, {26'h0, pin_oe});
			chk("count_in", {33'h0, i[1]}, {33'h0, ud});
			chk("int4", {33'h0, i[0]}, {33'h0, int4});
			chk("adc_trig", {33'h0, i[0] & i[1]}, {33'h0, adtr});
		end
		rd(a_data, 8'hff, ok);
		sdata <= 1'b1;
		sdrv <= 1'b1;
		p43 <= 1'b1;
		for (i = 0; i < 2; i++) begin
			wr(a_mode, i[0] ? 8'h0c : 8'h00, ok);
			repeat (5) @(posedge clk);
			chk("int0", {33'h0, i[0]}, {33'h0, int0});
			chk("p43_in", {33'h0, !i[0]}, {33'h0, p43_in});
			chk("ser_oe", {33'h0, !i[0]}, {33'h0, ser_oe});
			chk("ser_out", {33'h0, !i[0]}, {33'h0, ser_o & ser_oe});
		end
		wr(a_data, 8'h3c, ok);
		repeat (3) @(posedge clk);
		for (i = 0; i < 3; i++) begin
			pwr <= hm[i];
			wr(a_data, 8'(i + 1), ok);
			repeat (3) @(posedge clk);
			chk("pin_hold", 34'h3c, {26'h0, pin_o});
		end
		pwr <= epio_pkg::EPIO_PWR_STANDBY;
		repeat (3) @(posedge clk);
		chk("pin_oe", 34'h0, {26'h0, pin_oe});
		pwr <= epio_pkg::EPIO_PWR_SUBACTIVE;
		repeat (3) @(posedge clk);
		chk("pin_out", 34'h03, {26'h0, pin_o});
		// Second reset in mid-run, mode, direction and data registers hold non-reset values
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk("pin_oe", 34'h0, {26'h0, pin_oe});
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd(a_mode, 8'hc0, ok);
		rd(a_data, ext, ok);
		// Let the watcher take the last answer before closing
		repeat (2) @(posedge clk);
		chk("notes_left", 34'h0, 34'(exp_q.size()));
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
